// file: cpi_image_reader.sv
`timescale 1ns/1ps
module cpi_image_reader
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from bench
  input wire logic go,
  // image stream
  input wire logic img_valid,
  input wire logic [7:0] img_byte,
  input wire logic img_hdr,
  output logic img_start,
  // collected header, byte 0 lowest
  output logic [63:0] hdr,
  output logic [3:0] cnt
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      img_start <= 1'b0;
      hdr <= 64'h0;
      cnt <= 4'h0;
    end
    else
    begin
      img_start <= go;
      // a new request restarts collection, only the byte seen with img_start dropped
      if (img_start)
        cnt <= 4'h0;
      else if (img_valid && img_hdr && cnt < 4'h8)
      begin
        hdr[8*cnt[2:0]+:8] <= img_byte;
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : cpi_image_reader

// file: cpi_pkg.sv
package cpi_pkg;
  typedef enum logic [2:0] {
    CPI_ERR_BADTRANS = 3'h0,
    CPI_ERR_UNKSTATE = 3'h1,
    CPI_ERR_MBXCFG = 3'h2,
    CPI_ERR_WDOG = 3'h3,
    CPI_ERR_OUTCFG = 3'h4,
    CPI_ERR_INCFG = 3'h5
  } cpi_err_t;
  typedef enum logic [1:0] {
    CPI_W8 = 2'h0,
    CPI_W16 = 2'h1,
    CPI_W32 = 2'h2,
    CPI_W64 = 2'h3
  } cpi_width_t;
endpackage : cpi_pkg

// file: cpi_regs.svh
`ifndef CPI_REGS_SVH
`define CPI_REGS_SVH
// register byte addresses
`define CPI_ADDR_CTRL 12'h000
`define CPI_ADDR_ORDER 12'h004
`define CPI_ADDR_ALSTAT 12'h008
`define CPI_ADDR_ALCODE 12'h00C
`define CPI_ADDR_HDR01 12'h010
`define CPI_ADDR_HDR23 12'h014
`define CPI_ADDR_ERRIN 12'h018
// field positions
`define CPI_ORD16_BIT 0
`define CPI_ORD32_BIT 1
`define CPI_ORD64_BIT 2
`define CPI_ALSTAT_ERR_BIT 4
`define CPI_CTRL_ACK_BIT 0
`define CPI_CTRL_STORE_BIT 1
// reset values
`define CPI_ORDER_RST 3'h7
// status codes
`define CPI_CODE_NONE 16'h0000
`define CPI_CODE_BADTRANS 16'h0011
`define CPI_CODE_UNKSTATE 16'h0012
`define CPI_CODE_MBXCFG 16'h0016
`define CPI_CODE_WDOG 16'h001B
`define CPI_CODE_OUTCFG 16'h001D
`define CPI_CODE_INCFG 16'h001E
// header layout
`define CPI_HDR_BYTES 4'h8
`endif

// file: cpi_swap.sv
`timescale 1ns/1ps
`include "cpi_regs.svh"
module cpi_swap
(
  // data item
  input wire logic [63:0] din,
  input wire logic [1:0] width,
  // byte-order settings, 1 = little endian
  input wire logic [2:0] order,
  // result
  output logic [63:0] dout
);
  // ---------------------------------------------
  // byte reversal within the item width
  // ---------------------------------------------
  function automatic logic [63:0] cpi_rev(input logic [63:0] d,
    input logic [3:0] n);
    logic [63:0] r;
    r = d;
    for (int i = 0; i < 8; i++)
      if (i < n)
        r[i*8 +: 8] = d[(n - 1 - i)*8 +: 8];
    return r;
  endfunction : cpi_rev

  wire sel16 = (width == cpi_pkg::CPI_W16) & order[`CPI_ORD16_BIT];
  wire sel32 = (width == cpi_pkg::CPI_W32) & order[`CPI_ORD32_BIT];
  wire sel64 = (width == cpi_pkg::CPI_W64) & order[`CPI_ORD64_BIT];
  // local bus is big endian; swap only when little endian chosen
  assign dout = sel16 ? cpi_rev(din, 4'h2) :
                sel32 ? cpi_rev(din, 4'h4) :
                sel64 ? cpi_rev(din, 4'h8) : din;
endmodule : cpi_swap

// file: cpi_top.sv
`timescale 1ns/1ps
`include "cpi_regs.svh"
module cpi_top
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // diagnostic sources
  input wire logic new_diag_msg,
  input wire logic [15:0] bus_diag_status,
  input wire logic [15:0] mod_error_code,
  input wire logic [15:0] mod_error_pos,
  // state machine error events, one-cycle pulses
  input wire logic [5:0] sm_err_event,
  // retained order storage
  input wire logic nv_valid,
  input wire logic [2:0] nv_order,
  output logic nv_wr,
  output logic [2:0] nv_wdata,
  // module data item stream from local bus
  input wire logic mod_valid,
  input wire logic [63:0] mod_data,
  input wire logic [1:0] mod_width,
  // input process image byte stream
  input wire logic img_start,
  output logic img_valid,
  output logic [7:0] img_byte,
  output logic img_hdr,
  // swapped item out
  output logic item_valid,
  output logic [63:0] item_data
);
  // ---------------------------------------------
  // header snapshot
  // ---------------------------------------------
  logic [63:0] hdr_ff;
  // all words taken in one cycle, but refreshed every cycle, so the eight played-out bytes can mix epochs
  wire [63:0] nxt_hdr = {mod_error_pos, mod_error_code,
    bus_diag_status, 15'h0000, new_diag_msg};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hdr_ff <= 64'h0000000000000000;
    else
      hdr_ff <= nxt_hdr;

  // ---------------------------------------------
  // image byte sequencer
  // ---------------------------------------------
  logic [3:0] idx_ff;
  logic hdr_run_ff;
  logic [7:0] byte_ff;
  logic bval_ff;
  wire hdr_active = hdr_run_ff & (idx_ff < `CPI_HDR_BYTES);
  wire [3:0] nxt_idx = img_start ? 4'h0 : (idx_ff + 4'h1);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      idx_ff <= 4'h0;
      hdr_run_ff <= 1'b0;
    end
    else if (img_start | hdr_active)
    begin
      idx_ff <= nxt_idx;
      hdr_run_ff <= img_start | (idx_ff != (`CPI_HDR_BYTES - 4'h1));
    end

  // ---------------------------------------------
  // byte order and module data
  // ---------------------------------------------
  logic [2:0] order_ff;
  logic [63:0] swapped;
  cpi_swap u_swap
  (
    .din(mod_data),
    .width(mod_width),
    .order(order_ff),
    .dout(swapped)
  );
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      item_valid <= 1'b0;
      item_data <= 64'h0000000000000000;
    end
    else
    begin
      // module items dropped, not delayed, while header plays out
      item_valid <= mod_valid & ~hdr_active;
      item_data <= swapped;
    end

  wire [7:0] hdr_byte = hdr_ff[idx_ff[2:0]*8 +: 8];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      byte_ff <= 8'h00;
      bval_ff <= 1'b0;
    end
    else
    begin
      byte_ff <= hdr_byte;
      bval_ff <= hdr_active;
    end
  assign img_valid = bval_ff;
  assign img_byte = byte_ff;
  assign img_hdr = bval_ff;

  // ---------------------------------------------
  // apb decode
  // ---------------------------------------------
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire hit_ctrl = paddr == `CPI_ADDR_CTRL;
  wire hit_order = paddr == `CPI_ADDR_ORDER;
  wire hit_stat = paddr == `CPI_ADDR_ALSTAT;
  wire hit_code = paddr == `CPI_ADDR_ALCODE;
  wire hit_h01 = paddr == `CPI_ADDR_HDR01;
  wire hit_h23 = paddr == `CPI_ADDR_HDR23;
  wire hit_ein = paddr == `CPI_ADDR_ERRIN;
  wire mapped = hit_ctrl | hit_order | hit_stat | hit_code | hit_h01 |
    hit_h23 | hit_ein;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ---------------------------------------------
  // retained order settings
  // ---------------------------------------------
  logic loaded_ff;
  logic nvwr_ff;
  wire ord_wr = wr_en & hit_order;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      order_ff <= `CPI_ORDER_RST;
      loaded_ff <= 1'b0;
    end
    else if (ord_wr)
    begin
      order_ff <= pwdata[2:0];
      loaded_ff <= 1'b1;
    end
    else if (!loaded_ff)
    begin
      // take stored setting after reset release, else keep default
      if (nv_valid)
        order_ff <= nv_order;
      loaded_ff <= 1'b1;
    end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      nvwr_ff <= 1'b0;
    else
      nvwr_ff <= ord_wr;
  assign nv_wr = nvwr_ff;
  assign nv_wdata = order_ff;

  // ---------------------------------------------
  // application-layer status and code
  // ---------------------------------------------
  function automatic logic [15:0] cpi_code(input logic [5:0] ev);
    logic [15:0] c;
    c = `CPI_CODE_NONE;
    if (ev[cpi_pkg::CPI_ERR_INCFG]) c = `CPI_CODE_INCFG;
    if (ev[cpi_pkg::CPI_ERR_OUTCFG]) c = `CPI_CODE_OUTCFG;
    if (ev[cpi_pkg::CPI_ERR_WDOG]) c = `CPI_CODE_WDOG;
    if (ev[cpi_pkg::CPI_ERR_MBXCFG]) c = `CPI_CODE_MBXCFG;
    if (ev[cpi_pkg::CPI_ERR_UNKSTATE]) c = `CPI_CODE_UNKSTATE;
    if (ev[cpi_pkg::CPI_ERR_BADTRANS]) c = `CPI_CODE_BADTRANS;
    return c;
  endfunction : cpi_code

  logic err_ff;
  logic [15:0] code_ff;
  wire any_err = |sm_err_event;
  wire ack = wr_en & hit_ctrl & pwdata[`CPI_CTRL_ACK_BIT];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      err_ff <= 1'b0;
      code_ff <= `CPI_CODE_NONE;
    end
    else if (any_err)
    begin
      // a new error wins over a same-cycle acknowledge
      err_ff <= 1'b1;
      code_ff <= cpi_code(sm_err_event);
    end
    else if (ack)
    begin
      err_ff <= 1'b0;
      code_ff <= `CPI_CODE_NONE;
    end

  // ---------------------------------------------
  // read mux
  // ---------------------------------------------
  wire [31:0] rd_stat = {27'h0000000, err_ff, 4'h0};
  wire [31:0] rd_mux =
    hit_order ? {29'h00000000, order_ff} :
    hit_stat ? rd_stat :
    hit_code ? {16'h0000, code_ff} :
    hit_h01 ? hdr_ff[31:0] :
    hit_h23 ? hdr_ff[63:32] :
    hit_ein ? {26'h0000000, sm_err_event} : 32'h00000000;
  assign prdata = rd_en ? rd_mux : 32'h00000000;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  sequence hdr_play_s;
    img_start ##1 hdr_active [*8];
  endsequence
  hdr_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    hdr_play_s |=> !hdr_active)
    else $error("header length not eight bytes");
  hdr_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    hdr_active |=> !item_valid)
    else $error("module data during header");
  // first edge after a release still shows the reset snapshot
  flag_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> hdr_ff[0] == $past(new_diag_msg))
    else $error("diag flag not mirrored");
  zero_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    hdr_ff[15:1] == 15'h0000)
    else $error("undefined header bits set");
  words_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |->
    hdr_ff[63:16] == {$past(mod_error_pos), $past(mod_error_code),
    $past(bus_diag_status)})
    else $error("header words stale");
  bus_view_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en & hit_h23 |-> prdata == hdr_ff[63:32])
    else $error("header word read mismatch");
  err_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    any_err |=> err_ff && code_ff != `CPI_CODE_NONE)
    else $error("error not latched");
  wdog_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    sm_err_event == 6'h08 |=> code_ff == `CPI_CODE_WDOG)
    else $error("watchdog code wrong");
  trans_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    sm_err_event[0] |=> code_ff == `CPI_CODE_BADTRANS)
    else $error("transition code wrong");
  swap16_a: assert property (@(posedge pclk) disable iff (!presetn)
    mod_valid && !hdr_active && mod_width == 2'h1 && order_ff[0] |=>
    item_data[15:0] == {$past(mod_data[7:0]), $past(mod_data[15:8])})
    else $error("16-bit swap wrong");
  order_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    !loaded_ff && !nv_valid && !ord_wr |=> order_ff == `CPI_ORDER_RST)
    else $error("order default wrong");
endmodule : cpi_top

// file: cpi_top_tb.sv
`timescale 1ns/1ps
module cpi_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err_seen, new_diag_msg = 0, nv_valid = 0;
  logic [15:0] bus_diag_status = 0, mod_error_code = 0, mod_error_pos = 0;
  logic [5:0] sm_err_event = 0;
  logic [2:0] nv_order = 0, nv_wdata, nv_seen, ord;
  logic nv_wr, mod_valid = 0, go = 0, img_start, img_valid, img_hdr;
  logic [63:0] mod_data = 0, item_data, hdr, exp;
  logic [1:0] mod_width = 0;
  logic [7:0] img_byte;
  logic [3:0] cnt;
  logic item_valid;
  int mismatches = 0, n_tests = 0, cyc = 0, k;
  logic [15:0] codes [6] = '{16'h0011, 16'h0012, 16'h0016, 16'h001B,
                             16'h001D, 16'h001E};
  always #4 pclk = ~pclk;
  cpi_top cpi_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .new_diag_msg(new_diag_msg), .bus_diag_status(bus_diag_status),
    .mod_error_code(mod_error_code), .mod_error_pos(mod_error_pos),
    .sm_err_event(sm_err_event), .nv_valid(nv_valid), .nv_order(nv_order),
    .nv_wr(nv_wr), .nv_wdata(nv_wdata), .mod_valid(mod_valid),
    .mod_data(mod_data), .mod_width(mod_width), .img_start(img_start),
    .img_valid(img_valid), .img_byte(img_byte), .img_hdr(img_hdr),
    .item_valid(item_valid), .item_data(item_data));
  cpi_image_reader cpi_image_reader_inst (.pclk(pclk), .presetn(presetn),
    .go(go), .img_valid(img_valid), .img_byte(img_byte), .img_hdr(img_hdr),
    .img_start(img_start), .hdr(hdr), .cnt(cnt));
  always @(posedge pclk)
  begin
    if (nv_wr)
      nv_seen <= nv_wdata;
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    n_tests++;
    if (got !== want)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input int d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [63:0] swp(logic [63:0] d, int nb, logic le);
    logic [63:0] r;
    r = d;
    for (int i = 0; i < nb; i++)
      if (le)
        r[8*i+:8] = d[8*(nb-1-i)+:8];
    return r;
  endfunction : swp
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial
  begin
    void'($urandom(32'h54BE));
    do_reset();
    apb(0, 12'h004, 0);
    chk(rd, 64'h7);
    apb(0, 12'h00C, 0);
    chk(rd, 64'h0);
    apb(0, 12'h01C, 0);
    chk({rd, 31'h0, err_seen}, 64'h1);
    // header: random status, collected by the reader
    new_diag_msg <= 1'b1;
    bus_diag_status <= $urandom;
    mod_error_code <= $urandom;
    mod_error_pos <= $urandom;
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    k = 0;
    while (cnt != 4'h8 && k < 40)
    begin
      @(posedge pclk);
      k++;
    end
    exp = {mod_error_pos, mod_error_code, bus_diag_status, 16'h0001};
    chk(hdr, exp);
    chk(cnt, 64'h8);
    apb(0, 12'h014, 0);
    chk(rd, exp[63:32]);
    apb(0, 12'h010, 0);
    chk(rd, exp[31:0]);
    // every error source, then all at once for priority
    for (int i = 0; i < 7; i++)
    begin
      @(posedge pclk);
      sm_err_event <= (i == 6) ? 6'h3F : 6'h1 << i;
      @(posedge pclk);
      sm_err_event <= 6'h0;
      apb(0, 12'h008, 0);
      chk(rd[4], 1'b1);
      apb(0, 12'h00C, 0);
      chk(rd, codes[i % 6]);
      apb(1, 12'h000, 1);
      apb(0, 12'h00C, 0);
      chk(rd, 64'h0);
    end
    // byte order of items under random order settings
    for (int i = 0; i < 24; i++)
    begin
      if (i % 4 == 0)
      begin
        ord = $urandom;
        apb(1, 12'h004, ord);
        // nv_wr shows one edge after the write; nv_seen one edge later
        repeat (3) @(posedge pclk);
        chk(nv_seen, ord);
      end
      @(posedge pclk);
      mod_width <= i % 4;
      mod_data <= {$urandom, $urandom} & ((65'h1 << (8 << (i % 4))) - 1);
      mod_valid <= 1'b1;
      @(posedge pclk);
      mod_valid <= 1'b0;
      @(posedge pclk);
      exp = swp(mod_data, 1 << (i % 4), (i % 4 == 0) ? 1'b0 : ord[i%4-1]);
      chk({item_valid, item_data}, {1'b1, exp});
    end
    // retained setting reloaded after reset
    nv_valid <= 1'b1;
    nv_order <= 3'h2;
    do_reset();
    apb(0, 12'h004, 0);
    chk(rd, 64'h2);
    give_verdict();
  end
endmodule : cpi_top_tb
